// >>> src/ifd_decoder.sv
// ifd_decoder: splits 16-bit instruction words into operand fields
// assumes program memory offers one word per instruction cycle
// What this block does
// - most instructions one word; some two or three
// - split word into opcode class and operands
// - destination bit picks accumulator or file
// - access bit picks access RAM or bank
// - bit field picks bit 0 to 7
// - file address is 8 bits wide
// - move carries 12-bit source and destination
// - indexed move adds 7-bit offsets to pointer
// - literals of 6, 8, 12 or 20 bits
// - continuation words start 1111, alone act NOP
// - one cycle; taken or jump adds NOP cycle
// - double-word instructions take two cycles
// - instruction cycle is four oscillator periods
// - table instructions carry pointer mode field
// - call/return carry mode; others no operand
// - fast select bit governs shadow registers
`timescale 1ns/1ps
module ifd_decoder
  import ifd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // program memory side
  input wire logic [15:0] wordIn,
  input wire logic wordValid,
  input wire logic condTrue,
  input wire logic [11:0] third_indirect_pointer,
  output logic wordReady,
  // decoded result
  output ifd_fields_type fields,
  output logic decodeValid,
  output logic nopCycle,
  // axi4-lite write channels
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read channels
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  //////////////////////////////////////////////////////////////////////////
  // internal state
  logic [1:0] phase; // quarter within the cycle
  logic cycleEnd; // one pulse per instruction cycle
  ifd_state_type state; // decode sequencer
  logic [15:0] held0; // first word of a multi-word instruction
  logic [15:0] held1; // second word
  ifd_class_type heldCls; // class of the instruction being gathered
  logic [1:0] ctrl; // run and extended enables
  logic badWord; // sticky: continuation missing its marker
  logic setBad; // event that sets badWord
  logic [7:0] awAddrQ; // write address once taken
  logic awHave;
  logic [31:0] wDataQ; // write data once taken
  logic [3:0] wStrbQ;
  logic wHave;
  logic [15:0] wordA; // assembled first word
  logic [15:0] wordB; // assembled second word
  ifd_class_type curCls; // class of the word at hand
  logic take; // word accepted this cycle
  logic emit; // instruction complete this cycle
  ifd_fields_type next_fields;

  // instruction cycle timing from the divider
  ifd_phase u_phase (
    .clk(clk),
    .reset(reset),
    .phase(phase),
    .cycleEnd(cycleEnd)
  );

  //////////////////////////////////////////////////////////////////////////
  // opcode class of a first word; patterns fixed by this core
  function automatic ifd_class_type classify(input logic [15:0] w,
                                             input logic ext);
    ifd_class_type c;
    c = CLS_BYTE; // byte formats fill the remaining space
    if (w[15:12] == IFD_CONT_NIBBLE)
      c = CLS_NOP; // lone continuation word
    else if (w[15:12] == 4'hc)
      c = CLS_MOVE2;
    else if (w[15:12] >= 4'h7 && w[15:12] <= 4'hb)
      c = CLS_BIT;
    else if (w[15:12] == 4'hd)
      c = CLS_BRA11;
    else if (w[15:8] == 8'hef || w[15:9] == 7'h76)
      c = CLS_CTRL20;
    else if (w[15:8] == 8'hee)
      c = CLS_LIT12;
    else if (w[15:8] == 8'heb)
      c = ext ? CLS_INDEXED : CLS_NOP; // extended only when enabled
    else if (w[15:8] == 8'he8)
      c = ext ? CLS_LIT6 : CLS_NOP;
    else if (w[15:12] == 4'he)
      c = CLS_BRCOND;
    else if (w[15:5] == 11'h003)
      c = CLS_MOVE3;
    else if (w[15:4] == 12'h000) begin
      if (w[3])
        c = CLS_TABLE;
      else if (w[3:1] == 3'h1)
        c = CLS_RETURN;
      else
        c = CLS_NOP; // operand-free control word
    end else if (w[15:12] == 4'h0)
      c = CLS_LIT8;
    return c;
  endfunction

  // program words per class
  function automatic logic [1:0] wordsOf(input ifd_class_type c);
    case (c)
      CLS_MOVE2, CLS_CTRL20, CLS_LIT12, CLS_INDEXED: wordsOf = 2'h2;
      CLS_MOVE3: wordsOf = 2'h3;
      default: wordsOf = 2'h1;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // word assembly and acceptance
  always_comb begin
    wordA = (state == ST_FIRST) ? wordIn : held0;
    wordB = (state == ST_SECOND) ? wordIn : held1;
    curCls = (state == ST_FIRST) ? classify(wordIn, ctrl[IFD_CTRL_EXT_BIT])
                                 : heldCls;
    take = cycleEnd && wordValid && wordReady;
    setBad = take && state != ST_FIRST &&
             wordIn[15:12] != IFD_CONT_NIBBLE;
    emit = take && !setBad &&
           ((state == ST_FIRST && wordsOf(curCls) == 2'h1) ||
            (state == ST_SECOND && wordsOf(curCls) == 2'h2) ||
            state == ST_THIRD);
  end

  //////////////////////////////////////////////////////////////////////////
  // field extraction by class
  always_comb begin
    next_fields = '0;
    next_fields.cls = curCls;
    next_fields.wordCount = wordsOf(curCls);
    next_fields.execCycles = 2'h1;
    case (curCls)
      CLS_BYTE: begin
        next_fields.destToFile = wordA[9];
        next_fields.accessBanked = wordA[8];
        next_fields.fileAddr = wordA[7:0];
      end
      CLS_BIT: begin
        next_fields.bitPos = wordA[11:9];
        next_fields.accessBanked = wordA[8];
        next_fields.fileAddr = wordA[7:0];
      end
      CLS_LIT8: next_fields.literal = {12'h000, wordA[7:0]};
      CLS_LIT6: next_fields.literal = {14'h0000, wordA[5:0]};
      CLS_LIT12: begin
        next_fields.pointerSel = wordA[5:4];
        next_fields.literal = {8'h00, wordA[3:0], wordIn[7:0]};
        next_fields.execCycles = 2'h2;
      end
      CLS_MOVE2: begin
        next_fields.srcAddr = wordA[11:0];
        next_fields.dstAddr = wordIn[11:0];
        next_fields.execCycles = 2'h2;
      end
      CLS_MOVE3: begin
        next_fields.srcAddr = wordB[11:0];
        next_fields.dstAddr = wordIn[11:0];
        next_fields.execCycles = 2'h3;
      end
      CLS_INDEXED: begin
        // offsets are unsigned; the pointer wraps within 12 bits
        next_fields.srcAddr = third_indirect_pointer +
                              {5'h00, wordA[6:0]};
        next_fields.dstAddr = third_indirect_pointer +
                              {5'h00, wordIn[6:0]};
        next_fields.execCycles = 2'h2;
      end
      CLS_CTRL20: begin
        next_fields.literal = {wordIn[11:0], wordA[7:0]};
        next_fields.fastSelect = (wordA[15:8] != 8'hef) &&
                                 wordA[8];
        next_fields.execCycles = 2'h2;
      end
      CLS_BRA11: begin
        next_fields.literal = {9'h000, wordA[10:0]};
        next_fields.execCycles = 2'h2;
      end
      CLS_BRCOND: begin
        next_fields.literal = {12'h000, wordA[7:0]};
        next_fields.execCycles = condTrue ? 2'h2 : 2'h1;
      end
      CLS_TABLE: next_fields.tableMode = wordA[1:0];
      CLS_RETURN: begin
        next_fields.fastSelect = wordA[0];
        next_fields.execCycles = 2'h2;
      end
      default: next_fields.execCycles = 2'h1;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // decode sequencer; one step per instruction cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= ST_FIRST;
      heldCls <= CLS_NOP;
      held0 <= 16'h0000;
      held1 <= 16'h0000;
    end else if (cycleEnd) begin
      case (state)
        ST_FIRST: begin
          if (take) begin
            held0 <= wordIn;
            heldCls <= curCls;
            if (!emit)
              state <= ST_SECOND;
            else if (next_fields.execCycles == 2'h2)
              state <= ST_EXTRA;
          end
        end
        ST_SECOND: begin
          if (setBad)
            state <= ST_FIRST; // drop the broken instruction
          else if (take) begin
            held1 <= wordIn;
            state <= emit ? ST_FIRST : ST_THIRD;
          end
        end
        ST_THIRD: begin
          if (take)
            state <= ST_FIRST;
        end
        default: state <= ST_FIRST; // extra cycle spent as NOP
      endcase
    end
  end

  // outputs toward execution, all registered
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fields <= '0;
      decodeValid <= 1'b0;
      nopCycle <= 1'b0;
      wordReady <= 1'b0;
    end else begin
      decodeValid <= emit;
      if (emit)
        fields <= next_fields;
      if (cycleEnd) begin
        // the word fetched during a flushed cycle is not consumed
        nopCycle <= (state == ST_FIRST && emit &&
                     next_fields.execCycles == 2'h2);
        wordReady <= ctrl[IFD_CTRL_RUN_BIT] &&
                     !(state == ST_FIRST && emit &&
                       next_fields.execCycles == 2'h2);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // axi4-lite write side; address and data may come in either order
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      awHave <= 1'b0;
      wHave <= 1'b0;
      awAddrQ <= 8'h00;
      wDataQ <= 32'h0000_0000;
      wStrbQ <= 4'h0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= IFD_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awAddrQ <= awaddr;
        awHave <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wDataQ <= wdata;
        wStrbQ <= wstrb;
        wHave <= 1'b1;
        wready <= 1'b0;
      end
      if (awHave && wHave && !bvalid) begin
        bvalid <= 1'b1;
        awHave <= 1'b0;
        wHave <= 1'b0;
        if (awAddrQ == IFD_CTRL_OFS || awAddrQ == IFD_STATUS_OFS)
          bresp <= IFD_RESP_OKAY;
        else
          bresp <= IFD_RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // control register; run gates word acceptance
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      ctrl <= IFD_CTRL_RESET;
    else if (awHave && wHave && !bvalid && awAddrQ == IFD_CTRL_OFS &&
             wStrbQ[0])
      ctrl <= wDataQ[1:0];
  end

  // sticky bad-continuation flag; a new event beats the clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      badWord <= 1'b0;
    else if (setBad)
      badWord <= 1'b1;
    else if (awHave && wHave && !bvalid && awAddrQ == IFD_STATUS_OFS &&
             wStrbQ[0] && wDataQ[IFD_ST_BAD_BIT])
      badWord <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // axi4-lite read side, answer one cycle after the address
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= IFD_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= IFD_RESP_OKAY;
      if (araddr == IFD_CTRL_OFS)
        rdata <= {30'h0, ctrl};
      else if (araddr == IFD_STATUS_OFS)
        rdata <= {20'h0, 4'(fields.cls), 2'h0, 2'(state), 3'h0, badWord};
      else if (araddr == IFD_FIELD_OFS)
        rdata <= {10'h0, fields.pointerSel, fields.fastSelect,
                  fields.tableMode, fields.execCycles, fields.wordCount,
                  fields.destToFile, fields.accessBanked, fields.bitPos,
                  fields.fileAddr};
      else if (araddr == IFD_ADDR_OFS)
        rdata <= {4'h0, fields.dstAddr, 4'h0, fields.srcAddr};
      else if (araddr == IFD_LIT_OFS)
        rdata <= {12'h000, fields.literal};
      else begin
        rdata <= 32'h0000_0000;
        rresp <= IFD_RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_CYCLE_FOUR: assert property (
    cycleEnd |=> !cycleEnd [*3] ##1 cycleEnd)
    else $error("instruction cycle is not four clocks");

  AST_LONE_CONT_NOP: assert property (
    take && state == ST_FIRST && wordIn[15:12] == IFD_CONT_NIBBLE
    |=> decodeValid && fields.cls == CLS_NOP)
    else $error("lone continuation word not a nop");

  AST_BAD_STICKY: assert property (
    setBad |=> badWord && state == ST_FIRST && !decodeValid)
    else $error("broken continuation not flagged");

  AST_MULTI_WAIT: assert property (
    take && state == ST_FIRST && wordsOf(curCls) != 2'h1
    |=> !decodeValid && state == ST_SECOND)
    else $error("multi-word instruction decoded early");

  AST_DOUBLE_TWO: assert property (
    emit && state == ST_SECOND && wordsOf(curCls) == 2'h2
    |=> decodeValid && fields.execCycles == 2'h2 && state == ST_FIRST)
    else $error("double-word instruction not two cycles");

  // the decode pulse marks the first of the four flushed clocks
  AST_EXTRA_NOP: assert property (
    state == ST_EXTRA && decodeValid
    |=> (state == ST_EXTRA && nopCycle && !decodeValid && !wordReady) [*3]
    ##1 (state == ST_FIRST && !nopCycle && !decodeValid))
    else $error("extra cycle not a nop");

  AST_BYTE_FIELDS: assert property (
    emit && curCls == CLS_BYTE |=> fields.destToFile == $past(wordIn[9])
      && fields.accessBanked == $past(wordIn[8])
      && fields.fileAddr == $past(wordIn[7:0]))
    else $error("byte operand fields wrong");

  AST_BIT_POS: assert property (
    emit && curCls == CLS_BIT |=> fields.bitPos == $past(wordIn[11:9]))
    else $error("bit position field wrong");

  AST_TABLE_MODE: assert property (
    emit && curCls == CLS_TABLE
    |=> fields.tableMode == $past(wordIn[1:0]) && fields.literal == 20'h0)
    else $error("table mode field wrong");

  COV_TWO_WORD: cover property (emit && state == ST_SECOND);
  COV_THREE_WORD: cover property (emit && state == ST_THIRD);
  COV_EXTRA: cover property (state == ST_EXTRA ##4 wordReady);
  COV_BAD: cover property (setBad);

endmodule

// >>> src/ifd_phase.sv
// ifd_phase: splits the clock into instruction cycles of four periods
// assumes the core clock stands for the oscillator
`timescale 1ns/1ps
module ifd_phase
  import ifd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // phase outputs
  output logic [1:0] phase,
  output logic cycleEnd
);

  //////////////////////////////////////////////////////////////////////////
  // free running quarter counter; cycleEnd marks the last quarter
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase <= 2'h0;
      cycleEnd <= 1'b0;
    end else begin
      phase <= (phase == IFD_PHASE_LAST) ? 2'h0 : phase + 2'h1;
      cycleEnd <= (phase == IFD_PHASE_LAST - 2'h1);
    end
  end

endmodule

// >>> src/ifd_pkg.sv
// ifd_pkg: shared constants and types for the instruction field decoder
// assumes one 200 MHz clock; instruction words arrive from program memory
package ifd_pkg;

  // clock and instruction cycle timing
  localparam int IFD_CLK_PERIOD_PS = 5000; // 200 MHz
  localparam int IFD_OSC_PER_CYCLE = 4; // oscillator periods per cycle
  localparam logic [1:0] IFD_PHASE_LAST = 2'(IFD_OSC_PER_CYCLE - 1);

  // word layout
  localparam logic [3:0] IFD_CONT_NIBBLE = 4'hf; // continuation marker

  // register byte offsets
  localparam logic [7:0] IFD_CTRL_OFS = 8'h00;
  localparam logic [7:0] IFD_STATUS_OFS = 8'h04;
  localparam logic [7:0] IFD_FIELD_OFS = 8'h08;
  localparam logic [7:0] IFD_ADDR_OFS = 8'h0c;
  localparam logic [7:0] IFD_LIT_OFS = 8'h10;

  // control bits and reset value
  localparam int IFD_CTRL_RUN_BIT = 0;
  localparam int IFD_CTRL_EXT_BIT = 1;
  localparam logic [1:0] IFD_CTRL_RESET = 2'h1;

  // status bit positions
  localparam int IFD_ST_BAD_BIT = 0;
  localparam int IFD_ST_STATE_POS = 4;
  localparam int IFD_ST_CLASS_POS = 8;

  // bus responses
  localparam logic [1:0] IFD_RESP_OKAY = 2'h0;
  localparam logic [1:0] IFD_RESP_SLVERR = 2'h2;

  // instruction format classes
  typedef enum logic [3:0] {
    CLS_NOP, CLS_BYTE, CLS_BIT, CLS_LIT8, CLS_LIT6, CLS_LIT12,
    CLS_MOVE2, CLS_MOVE3, CLS_INDEXED, CLS_CTRL20, CLS_BRA11,
    CLS_BRCOND, CLS_TABLE, CLS_RETURN
  } ifd_class_type;

  // decode sequencer states
  typedef enum logic [1:0] {
    ST_FIRST, ST_SECOND, ST_THIRD, ST_EXTRA
  } ifd_state_type;

  // decoded instruction, one bundle
  typedef struct packed {
    ifd_class_type cls;
    logic [1:0] wordCount;
    logic [1:0] execCycles;
    logic destToFile;
    logic accessBanked;
    logic [2:0] bitPos;
    logic [7:0] fileAddr;
    logic [11:0] srcAddr;
    logic [11:0] dstAddr;
    logic [19:0] literal;
    logic [1:0] tableMode;
    logic fastSelect;
    logic [1:0] pointerSel;
  } ifd_fields_type;

endpackage

// >>> tb/ifd_prog_mem.sv
// ifd_prog_mem: program memory model that feeds instruction words
// assumes the decoder takes a word on every fourth edge after reset
`timescale 1ns/1ps
module ifd_prog_mem (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // word link
  input wire logic wordReady,
  output logic [15:0] wordIn,
  output logic wordValid
);
  logic [15:0] words[$]; // words waiting to be offered
  logic [1:0] ph; // own copy of the instruction cycle phase

  ////////////////////////////////////////////////////////////////////////
  // queue filled by the bench between clock edges
  task automatic push(input logic [15:0] w);
    words.push_back(w);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // offer head word, hold it until taken at the cycle end
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ph <= 2'h0;
      wordValid <= 1'b0;
      wordIn <= 16'h0;
    end else begin
      ph <= ph + 2'h1;
      if (wordValid && wordReady && ph == 2'h3) begin
        void'(words.pop_front());
      end
      if (words.size() > 0) begin
        wordValid <= 1'b1;
        wordIn <= words[0];
      end else begin
        // idle bus toggles so a stale word is never mistaken for data
        wordValid <= 1'b0;
        wordIn <= ~wordIn;
      end
    end
  end
endmodule

// >>> tb/instruction_field_decoder_bench.sv
// instruction_field_decoder_bench: random and corner decode tests
// assumes ifd_pkg, ifd_decoder and ifd_prog_mem are compiled first
`timescale 1ns/1ps
module instruction_field_decoder_bench
  import ifd_pkg::*;
;
  localparam int W = $bits(ifd_fields_type);
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic condTrue = 1'b0;
  logic [11:0] ptr = 12'h0;
  logic [15:0] wordIn;
  logic wordValid, wordReady, decodeValid, nopCycle, dvPrev;
  ifd_fields_type fields;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int failCount = 0, numChecks = 0, cyc = 0, lastDv = 0, dvCount = 0;

  ////////////////////////////////////////////////////////////////////////
  always #2.5 clk = ~clk;

  ifd_decoder DUT (.clk(clk), .reset(reset), .wordIn(wordIn),
    .wordValid(wordValid), .condTrue(condTrue),
    .third_indirect_pointer(ptr), .wordReady(wordReady), .fields(fields),
    .decodeValid(decodeValid), .nopCycle(nopCycle), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));

  ifd_prog_mem mem (.clk(clk), .reset(reset), .wordReady(wordReady),
    .wordIn(wordIn), .wordValid(wordValid));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [W-1:0] seen, exp);
    numChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task testDone();
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // watchdog; the whole run needs well under this many cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failCount++;
      testDone();
    end
  end

  // decode strobe must be a single-cycle pulse
  always @(posedge clk) begin
    dvPrev <= decodeValid;
    if (decodeValid === 1'b1) dvCount++;
    if (dvPrev === 1'b1) check("pulse", decodeValid, 1'b0);
  end

  ////////////////////////////////////////////////////////////////////////
  // bus master tasks; a stuck response is caught by the watchdog
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    r = 2'h3;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (r === 2'h3) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
      end
    end
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    r = 2'h3;
    d = '0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (r === 2'h3) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // expected bundle with every unused field zero
  function automatic ifd_fields_type fb(ifd_class_type c, int wc, int ec);
    fb = '0;
    fb.cls = c;
    fb.wordCount = 2'(wc);
    fb.execCycles = 2'(ec);
  endfunction

  // feed an instruction, wait for its decode, compare
  task automatic run(input logic [15:0] w1, w2, w3,
                     input ifd_fields_type e, input bit tm, full);
    int t;
    t = 0;
    #1;
    mem.push(w1);
    if (e.wordCount > 1) mem.push(w2);
    if (e.wordCount > 2) mem.push(w3);
    do begin
      @(posedge clk);
      t++;
    end while (decodeValid !== 1'b1 && t < 80);
    check("decoded", decodeValid, 1'b1);
    if (full) check("fields", fields, e);
    check("cls", fields.cls, e.cls);
    check("cycles", fields.execCycles, e.execCycles);
    check("nop", nopCycle, e.wordCount == 1 && e.execCycles == 2);
    if (tm) check("spacing", cyc - lastDv, 4);
    lastDv = cyc;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    ifd_fields_type e;
    logic [15:0] w, v;
    logic [31:0] d;
    logic [1:0] r;
    void'($urandom(32'h346b3a43));
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    axr(IFD_CTRL_OFS, d, r);
    check("ctrl", d, {30'h0, IFD_CTRL_RESET});
    axr(8'h40, d, r);
    check("unmapped", r, IFD_RESP_SLVERR);
    axw(IFD_FIELD_OFS, 32'h1, r);
    check("readonly", r, IFD_RESP_SLVERR);
    // random byte and bit operations back to back
    for (int i = 0; i < 16; i++) begin
      if (i % 2) begin
        w = {4'($urandom_range(7, 11)), 12'($urandom)};
        e = fb(CLS_BIT, 1, 1);
        e.bitPos = w[11:9];
      end else begin
        w = {4'($urandom_range(1, 6)), 12'($urandom)};
        e = fb(CLS_BYTE, 1, 1);
        e.destToFile = w[9];
      end
      e.accessBanked = w[8];
      e.fileAddr = w[7:0];
      run(w, 0, 0, e, i > 0, 1);
    end
    // 8-bit literals
    for (int i = 0; i < 4; i++) begin
      w = {4'h0, 4'($urandom_range(1, 15)), 8'($urandom)};
      e = fb(CLS_LIT8, 1, 1);
      e.literal = {12'h0, w[7:0]};
      run(w, 0, 0, e, 0, 1);
    end
    // two word move at the address extremes, three word move from address 0
    e = fb(CLS_MOVE2, 2, 2);
    e.srcAddr = 12'hfff;
    run(16'hcfff, 16'hf000, 0, e, 0, 1);
    w = 16'hf000 | 16'($urandom_range(0, 4095));
    e = fb(CLS_MOVE3, 3, 3);
    e.srcAddr = 12'h000;
    e.dstAddr = w[11:0];
    run(16'h0061, 16'hf000, w, e, 0, 1);
    axr(IFD_STATUS_OFS, d, r);
    check("lastclass", d[11:8], 4'(CLS_MOVE3));
    // goto and call with fast select; 20-bit literal
    for (int s = 0; s < 3; s++) begin
      w = (s == 2) ? {8'hef, 8'($urandom)} : {7'h76, 1'(s), 8'($urandom)};
      v = {4'hf, 12'($urandom)};
      e = fb(CLS_CTRL20, 2, 2);
      e.literal = {v[11:0], w[7:0]};
      e.fastSelect = (s == 1);
      run(w, v, 0, e, 0, 1);
    end
    // return modes and table pointer modes
    for (int s = 0; s < 2; s++) begin
      e = fb(CLS_RETURN, 1, 2);
      e.fastSelect = 1'(s);
      run(16'h0002 | 16'(s), 0, 0, e, 0, 1);
    end
    for (int m = 0; m < 4; m++) begin
      e = fb(CLS_TABLE, 1, 1);
      e.tableMode = 2'(m);
      run(16'h0008 | 16'(m), 0, 0, e, 0, 1);
    end
    // conditional branch taken and not, then relative branch
    for (int c = 0; c < 2; c++) begin
      condTrue <= 1'(c);
      run(16'he200 | 16'($urandom_range(0, 255)), 0, 0,
          fb(CLS_BRCOND, 1, 1 + c), 0, 0);
    end
    run(16'hd000 | 16'($urandom_range(0, 2047)), 0, 0,
        fb(CLS_BRA11, 1, 2), 0, 0);
    // lone continuation word acts as a no-operation
    run(16'hf123, 0, 0, fb(CLS_NOP, 1, 1), 0, 1);
    // broken continuation is dropped and flagged
    // sample the pulse count only after the counter has seen this edge
    #1;
    v = 16'(dvCount);
    mem.push(16'hc123);
    mem.push(16'h1234);
    repeat (16) @(posedge clk);
    check("dropped", 16'(dvCount), v);
    axr(IFD_STATUS_OFS, d, r);
    check("badflag", d[IFD_ST_BAD_BIT], 1'b1);
    axw(IFD_STATUS_OFS, 32'h1, r);
    axr(IFD_STATUS_OFS, d, r);
    check("badclear", d[IFD_ST_BAD_BIT], 1'b0);
    // indexed move off the pointer, extended decode enabled
    axw(IFD_CTRL_OFS, 32'h3, r);
    check("wresp", r, IFD_RESP_OKAY);
    ptr <= 12'($urandom);
    w = 16'heb00 | 16'($urandom_range(0, 127));
    v = 16'hf000 | 16'($urandom_range(0, 4095));
    @(posedge clk);
    e = fb(CLS_INDEXED, 2, 2);
    e.srcAddr = ptr + 12'(w[6:0]);
    e.dstAddr = ptr + 12'(v[6:0]);
    run(w, v, 0, e, 0, 1);
    axr(IFD_ADDR_OFS, d, r);
    check("addrreg", d, {4'h0, e.dstAddr, 4'h0, e.srcAddr});
    // 12-bit literal with pointer select, then 6-bit literal
    w = 16'hee00 | 16'($urandom_range(0, 63));
    v = {4'hf, 12'($urandom)};
    e = fb(CLS_LIT12, 2, 2);
    e.pointerSel = w[5:4];
    e.literal = {8'h00, w[3:0], v[7:0]};
    run(w, v, 0, e, 0, 1);
    axr(IFD_LIT_OFS, d, r);
    check("litreg", d, {12'h000, e.literal});
    w = 16'he800 | 16'($urandom_range(0, 63));
    e = fb(CLS_LIT6, 1, 1);
    e.literal = {14'h0, w[5:0]};
    run(w, 0, 0, e, 0, 1);
    // stopped decoder refuses words
    axw(IFD_CTRL_OFS, 32'h0, r);
    repeat (8) @(posedge clk);
    check("halted", wordReady, 1'b0);
    axw(IFD_CTRL_OFS, 32'h1, r);
    testDone();
  end
endmodule
